// File: common/see_defines.svh
`ifndef SEE_DEFINES_SVH
`define SEE_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SEE_CLK_NS 50
`define SEE_PD_SETTLE_NS 3000
`define SEE_RELEASE_NS 3000
`define SEE_PD_SETTLE_CYC ((`SEE_PD_SETTLE_NS+`SEE_CLK_NS-1)/`SEE_CLK_NS)
`define SEE_RELEASE_CYC ((`SEE_RELEASE_NS+`SEE_CLK_NS-1)/`SEE_CLK_NS)
// ----------------------------------------
// Link framing
// ----------------------------------------
`define SEE_OPC_BITS 8
`define SEE_ADDR_BITS 24
`define SEE_PD_OP 8'hA5
`define SEE_SIG_OP 8'h5A
`define SEE_SIGNATURE 8'h3C
`endif

// File: common/see_pkg.sv
package see_pkg;
    typedef enum logic [2:0] {
        SEE_IDLE, SEE_OPC, SEE_DUMMY, SEE_SIG, SEE_IGN
    } see_ph_t;
    typedef enum logic [1:0] {
        SEE_STANDBY, SEE_SETTLE, SEE_PD, SEE_REL
    } see_pw_t;
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } see_pins_t;
    typedef struct packed {
        see_pins_t m;
        see_pins_t s;
        logic cs_d;
        logic sck_d;
        logic paused;
        logic pend;
        see_ph_t ph;
        see_pw_t pw;
        logic [4:0] cnt;
        logic [7:0] sr;
        logic [2:0] sig_i;
        logic so;
        logic [15:0] tmr;
        logic cmd_v;
        logic wr_go;
        logic wel_clr;
    } see_st_t;
endpackage

// File: rtl/see_front.sv
`timescale 1ns/1ps
`include "see_defines.svh"
module see_front #(
    parameter int ADDR_BITS = `SEE_ADDR_BITS,
    parameter bit DENSE = 1'b1,
    parameter logic [7:0] PD_OP = `SEE_PD_OP,
    parameter logic [7:0] SIG_OP = `SEE_SIG_OP,
    // Signature value is arbitrary
    parameter logic [7:0] SIGNATURE = `SEE_SIGNATURE
) (
    input wire logic clock,
    input wire logic rst,
    input see_pkg::see_pins_t pins,
    input wire logic busy,
    input wire logic wr_arm,
    input wire logic status_seq,
    input wire logic protect_pin_enable,
    output logic so,
    output logic so_oe,
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    output logic wr_start,
    output logic wel_clear,
    output logic status_wr_block,
    output logic deep_pd,
    output logic releasing
);
    import see_pkg::*;

    localparam int TDP_I = `SEE_PD_SETTLE_CYC;
    localparam int REL_I = `SEE_RELEASE_CYC;
    localparam logic [15:0] TDP_C = 16'(TDP_I);
    localparam logic [15:0] REL_C = 16'(REL_I);
    localparam logic [4:0] OPC_LAST = 5'(`SEE_OPC_BITS - 1);
    localparam logic [4:0] OPC_DONE = 5'(`SEE_OPC_BITS);
    localparam logic [4:0] ADR_LAST = 5'(ADDR_BITS - 1);

    see_st_t q;
    see_st_t n;
    logic sel;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic blocked;
    logic [7:0] op;

    // ----------------------------------------
    // Edge detection on synchronised pins
    // ----------------------------------------
    assign sel = !q.s.cs_n;
    assign cs_rise = q.s.cs_n && !q.cs_d;
    assign cs_fall = !q.s.cs_n && q.cs_d;
    // Paused link sees no clock edges
    assign sck_rise = sel && !q.paused && q.s.sck && !q.sck_d;
    assign sck_fall = sel && !q.paused && !q.s.sck && q.sck_d;
    assign op = {q.sr[6:0], q.s.si};
    // Dense parts honour the pin only with the enable bit set; others always do
    assign status_wr_block = DENSE && protect_pin_enable
        && !q.s.wp_n;
    assign blocked = (!DENSE && !q.s.wp_n)
        || (status_seq && status_wr_block);

    always_comb begin
        n = q;
        n.m = pins;
        n.s = q.m;
        n.cs_d = q.s.cs_n;
        n.sck_d = q.s.sck;
        n.cmd_v = 1'b0;
        n.wr_go = 1'b0;
        // Never touches a cycle already running
        n.wel_clr = !DENSE && !q.s.wp_n && !busy;

        // ----------------------------------------
        // Hold pause
        // ----------------------------------------
        if (!sel) begin
            n.paused = 1'b0;
            n.pend = 1'b0;
        end else if (!q.paused) begin
            if (!q.s.hold_n && !q.s.sck) begin
                n.paused = 1'b1;
            end else if (!q.s.hold_n || q.pend) begin
                // Clock high: wait for the falling edge
                n.pend = 1'b1;
                if (!q.s.sck && q.sck_d) begin
                    n.paused = 1'b1;
                    n.pend = 1'b0;
                end
            end
        end else if (q.s.hold_n && !q.s.sck) begin
            n.paused = 1'b0;
        end

        // ----------------------------------------
        // Power state timers
        // ----------------------------------------
        if (q.tmr != 16'h0000) begin
            n.tmr = q.tmr - 16'h0001;
        end
        unique case (q.pw)
            SEE_STANDBY: ;
            SEE_PD: ;
            SEE_SETTLE: begin
                if (q.tmr == 16'h0001) begin
                    n.pw = SEE_PD;
                end
            end
            SEE_REL: begin
                if (q.tmr == 16'h0001) begin
                    n.pw = SEE_STANDBY;
                end
            end
        endcase

        // ----------------------------------------
        // Command framing
        // ----------------------------------------
        if (cs_fall) begin
            // Only a select edge opens a frame
            n.ph = SEE_OPC;
            n.cnt = 5'h00;
        end else if (cs_rise) begin
            if (q.ph == SEE_OPC && q.cnt == OPC_DONE && q.sr == PD_OP
                && q.pw == SEE_STANDBY && !busy) begin
                n.pw = SEE_SETTLE;
                n.tmr = TDP_C;
            end else if ((q.ph == SEE_DUMMY || q.ph == SEE_SIG)
                && (q.pw == SEE_PD || q.pw == SEE_SETTLE)) begin
                n.pw = SEE_REL;
                n.tmr = REL_C;
            end
            if (wr_arm && q.pw == SEE_STANDBY && !blocked && !busy) begin
                n.wr_go = 1'b1;
            end
            // Partial bytes are dropped
            n.ph = SEE_IDLE;
            n.cnt = 5'h00;
        end else if (sck_rise) begin
            unique case (q.ph)
                SEE_IDLE: ;
                SEE_SIG: ;
                SEE_IGN: ;
                SEE_OPC: begin
                    n.sr = op;
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == OPC_DONE) begin
                        n.ph = SEE_IGN;
                    end else if (q.cnt == OPC_LAST) begin
                        if (op == SIG_OP) begin
                            if (q.pw != SEE_STANDBY || !busy) begin
                                n.ph = SEE_DUMMY;
                                n.cnt = 5'h00;
                            end else begin
                                n.ph = SEE_IGN;
                            end
                        end else if (q.pw != SEE_STANDBY) begin
                            n.ph = SEE_IGN;
                        end else if (op != PD_OP) begin
                            n.cmd_v = 1'b1;
                            n.ph = SEE_IGN;
                        end
                    end
                end
                SEE_DUMMY: begin
                    // Address value is only counted
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == ADR_LAST) begin
                        n.ph = SEE_SIG;
                        n.sig_i = 3'h7;
                    end
                end
            endcase
        end else if (sck_fall && q.ph == SEE_SIG) begin
            n.so = SIGNATURE[q.sig_i];
            // Index wraps so the byte repeats
            n.sig_i = q.sig_i - 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.m <= 5'h1F;
            q.s <= 5'h1F;
            q.cs_d <= 1'b1;
            q.pw <= SEE_STANDBY;
            q.ph <= SEE_IDLE;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign so = q.so;
    // Hold low drops the driver even before the pause
    assign so_oe = sel && q.s.hold_n && !q.paused
        && q.ph == SEE_SIG;
    assign cmd_byte = q.sr;
    assign cmd_valid = q.cmd_v;
    assign wr_start = q.wr_go;
    assign wel_clear = q.wel_clr;
    assign deep_pd = q.pw == SEE_PD || q.pw == SEE_SETTLE;
    assign releasing = q.pw == SEE_REL;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_pd_ign;
        @(posedge clock) disable iff (rst)
        q.cmd_v |-> $past(q.pw) == SEE_STANDBY;
    endproperty
    a_pd_ign: assert property (p_pd_ign)
        else $error("command passed in power-down");

    property p_pd_entry;
        @(posedge clock) disable iff (rst)
        $rose(q.pw == SEE_SETTLE) |->
            $past(q.ph) == SEE_OPC && $past(q.cnt) == OPC_DONE;
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down without exact deselect");

    property p_settle;
        @(posedge clock) disable iff (rst)
        $rose(q.pw == SEE_SETTLE) && !cs_fall |->
            ##[TDP_I:TDP_I] (q.pw == SEE_PD || q.pw == SEE_REL
            || q.pw == SEE_STANDBY);
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle delay wrong");

    property p_release;
        @(posedge clock) disable iff (rst)
        $rose(q.pw == SEE_REL) |-> $past(q.ph) == SEE_DUMMY
            || $past(q.ph) == SEE_SIG;
    endproperty
    a_release: assert property (p_release)
        else $error("release without signature command");

    property p_reset;
        @(posedge clock)
        $past(rst) |-> q.pw == SEE_STANDBY && !so_oe;
    endproperty
    a_reset: assert property (p_reset)
        else $error("not standby after reset");

    property p_so_edge;
        @(posedge clock) disable iff (rst)
        $changed(q.so) |-> $past(sck_fall) && $past(q.ph) == SEE_SIG;
    endproperty
    a_so_edge: assert property (p_so_edge)
        else $error("output changed off falling edge");

    property p_oe;
        @(posedge clock) disable iff (rst)
        so_oe |-> !q.s.cs_n && q.s.hold_n;
    endproperty
    a_oe: assert property (p_oe)
        else $error("output driven while released");

    property p_wr;
        @(posedge clock) disable iff (rst)
        wr_start |-> $past(cs_rise) && !$past(blocked);
    endproperty
    a_wr: assert property (p_wr)
        else $error("write start without deselect");

    property p_discard;
        @(posedge clock) disable iff (rst)
        cs_rise |=> q.ph == SEE_IDLE && q.cnt == 5'h00;
    endproperty
    a_discard: assert property (p_discard)
        else $error("partial command kept");
endmodule

// File: sim/see_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host serial master model
// ----------------------------------------
module see_host (
    input wire logic clock,
    input wire logic so,
    output see_pkg::see_pins_t pins
);
    import see_pkg::*;
    // Idle pins, hold kept high when unused
    initial begin
        pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // A falling select edge opens every frame
    task automatic sel();
        pins.cs_n = 1'b0;
        tick(4);
    endtask
    // Deselect right after the last bit, no spare rise
    task automatic desel();
        pins.sck = 1'b0;
        tick(4);
        pins.cs_n = 1'b1;
        pins.si = ~pins.si;
        tick(8);
    endtask
    // Drive si for the rise, read so late in the low phase
    task automatic shift(input int n, input logic [31:0] d,
            output logic [31:0] q);
        q = '0;
        for (int i = n - 1; i >= 0; i--) begin
            pins.sck = 1'b0;
            pins.si = d[i];
            tick(4);
            q = {q[30:0], so};
            pins.sck = 1'b1;
            tick(4);
        end
    endtask
    // Hold moves only while sck is low
    task automatic set_hold(input logic v);
        pins.sck = 1'b0;
        tick(4);
        pins.hold_n = v;
        tick(4);
    endtask
    // Hold moved while sck is high waits for the next fall
    task automatic hold_now(input logic v);
        pins.hold_n = v;
        tick(4);
    endtask
    task automatic set_wp(input logic v);
        pins.wp_n = v;
    endtask
endmodule

// File: sim/test_see_front.sv
`timescale 1ns/1ps
`include "see_defines.svh"
module test_see_front;
    import see_pkg::*;
    logic clock, rst, busy, wr_arm, status_seq, protect_pin_enable;
    see_pins_t pins;
    logic so, so_oe, cmd_valid, wr_start, wel_clear;
    logic so_line;
    logic status_wr_block, deep_pd, releasing;
    logic [7:0] cmd_byte;
    logic [31:0] q;
    int n_errors = 0, n_checks = 0, n_cmd = 0, n_wr = 0, c0;
    see_front i_see_front (.clock(clock), .rst(rst), .pins(pins),
        .busy(busy), .wr_arm(wr_arm), .status_seq(status_seq),
        .protect_pin_enable(protect_pin_enable), .so(so), .so_oe(so_oe),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .wr_start(wr_start),
        .wel_clear(wel_clear), .status_wr_block(status_wr_block),
        .deep_pd(deep_pd), .releasing(releasing));
    // Released line shows the inverse, so stale bits cannot pass
    assign so_line = so_oe ? so : !so;
    see_host i_see_host (.clock(clock), .so(so_line), .pins(pins));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ----------------------------------------
    // Pulse counters and helpers
    // ----------------------------------------
    always @(negedge clock) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (wr_start === 1'b1) n_wr++;
    end
    task automatic check(input logic [31:0] seen, exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h",
                $time, what, seen, exp);
        end
    endtask
    task automatic sh(input int n, input logic [31:0] d);
        i_see_host.shift(n, d, q);
    endtask
    task automatic frame(input int n, input logic [31:0] d);
        i_see_host.sel();
        sh(n, d);
        i_see_host.desel();
    endtask
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Long enough for every frame and both delays
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        give_verdict();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {busy, wr_arm, status_seq, protect_pin_enable} = 4'h0;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        i_see_host.tick(4);
        check({so_oe, deep_pd, releasing}, 0, "idle");
        i_see_host.sel();
        sh(8, `SEE_SIG_OP);
        sh(24, 32'hA5C3F0);
        sh(8, 0);
        check(q[7:0], `SEE_SIGNATURE, "sig");
        check(so_oe, 1'b1, "oe");
        i_see_host.set_hold(1'b0);
        check(so_oe, 1'b0, "hold oe");
        sh(3, 32'h7);
        i_see_host.set_hold(1'b1);
        sh(16, 0);
        check(q[15:0], {2{`SEE_SIGNATURE}}, "repeat");
        i_see_host.hold_now(1'b0);
        check(so_oe, 1'b0, "hold high oe");
        sh(3, 32'h5);
        i_see_host.set_hold(1'b1);
        sh(8, 0);
        check(q[7:0], `SEE_SIGNATURE, "late hold");
        i_see_host.desel();
        check(so_oe, 1'b0, "desel oe");
        check(n_cmd, 0, "sig cmd");
        busy = 1'b1;
        i_see_host.sel();
        sh(8, `SEE_SIG_OP);
        sh(32, 0);
        check(so_oe, 1'b0, "busy sig");
        i_see_host.desel();
        busy = 1'b0;
        frame(4, 32'hF);
        wr_arm = 1'b1;
        frame(8, 32'h02);
        check(cmd_byte, 8'h02, "byte");
        check(n_cmd, 32'd1, "write cmd");
        check(n_wr, 32'd1, "write");
        status_seq = 1'b1;
        protect_pin_enable = 1'b1;
        i_see_host.set_wp(1'b0);
        i_see_host.tick(6);
        check(status_wr_block, 1'b1, "block");
        check(wel_clear, 1'b0, "latch kept");
        frame(8, 32'h01);
        check(n_wr, 2'd1, "status blocked");
        protect_pin_enable = 1'b0;
        i_see_host.tick(4);
        check(status_wr_block, 1'b0, "pin off");
        frame(8, 32'h01);
        check(n_wr, 2'd2, "status ok");
        i_see_host.set_wp(1'b1);
        status_seq = 1'b0;
        wr_arm = 1'b0;
        frame(9, {`SEE_PD_OP, 1'b0});
        check(deep_pd, 1'b0, "late desel");
        frame(8, `SEE_PD_OP);
        check(deep_pd, 1'b1, "pd");
        c0 = n_cmd;
        wr_arm = 1'b1;
        frame(8, 32'h02);
        check(n_cmd, c0, "pd ignore cmd");
        check(n_wr, 32'd2, "pd ignore");
        wr_arm = 1'b0;
        frame(8, `SEE_SIG_OP);
        check(releasing, 1'b1, "release");
        i_see_host.tick(80);
        check({deep_pd, releasing}, 0, "standby");
        frame(8, `SEE_PD_OP);
        rst = 1'b1;
        i_see_host.tick(2);
        rst = 1'b0;
        i_see_host.tick(4);
        check(deep_pd, 1'b0, "power loss");
        give_verdict();
    end
endmodule
